// ---- sys_ctrl_chk.sv ----
// checker bound to the reset and power control top
`timescale 1ns/1ns
module sys_ctrl_chk
    import sys_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic brownout_detector_low,
    input wire logic brownout_detector_reset,
    input wire logic osc_running,
    input wire logic flash_init_done,
    input wire logic supply_present,
    input wire logic rtc_alarm,
    input wire logic chip_reset_n,
    input wire logic flash_init_start,
    input wire logic [31:0] fetch_addr,
    input wire logic vector_map_sram,
    input wire logic [1:0] clk_sel,
    input wire logic cpu_clock_run,
    input wire logic regulator_on,
    input wire logic battery_ram_hold,
    input wire logic rtc_alarm_out,
    input wire logic brownout_irq,
    input wire logic power_down_wake,
    input wire protect_t protect
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // flash seen ready while the sequencer waits on it
    sequence s_flash_ok;
        flash_init_start && flash_init_done;
    endsequence
    // wake pulse is one cycle; cpu stays stopped behind it
    sequence s_wake;
        power_down_wake ##1 (!power_down_wake && !cpu_clock_run);
    endsequence
    AST_PIN: assert property (!reset_pin_n |=> !chip_reset_n) else $error("pin low kept running");
    AST_WDT: assert property (watchdog_reset && regulator_on |=> !chip_reset_n) else $error("watchdog ignored");
    AST_BOD_RST: assert property (brownout_detector_reset && regulator_on |=> !chip_reset_n)
        else $error("brownout reset ignored");
    AST_BOD_IRQ: assert property ($rose(brownout_detector_low) |=> brownout_irq) else $error("no brownout irq");
    AST_RELEASE: assert property ($rose(chip_reset_n) |-> reset_pin_n && osc_running && $past(flash_init_done))
        else $error("reset released early");
    AST_FLASH: assert property (s_flash_ok |=> chip_reset_n && cpu_clock_run) else $error("no run after flash");
    AST_START: assert property ($rose(chip_reset_n) |-> fetch_addr == RESET_VECTOR_ADDR
        && clk_sel == CLK_SEL_IRC && vector_map_sram == MAP_BOOT_ROM) else $error("start state wrong");
    AST_PD_WAKE: assert property (power_down_wake |-> s_wake) else $error("wake pulse wrong");
    AST_DEEP_STAY: assert property (!regulator_on && !rtc_alarm && reset_pin_n && supply_present
        && $past(supply_present) |=> !regulator_on) else $error("deep left without cause");
    AST_RAM: assert property (!regulator_on || !supply_present |-> battery_ram_hold) else $error("ram not held");
    AST_ALARM: assert property (!regulator_on |-> rtc_alarm_out == rtc_alarm) else $error("alarm not out");
    AST_IAP: assert property (protect.iap_enable) else $error("iap blocked");
    AST_LOCK: assert property (!protect.isp_enable || protect.isp_sector0_lock
        || protect.isp_mass_erase_only |-> !protect.debug_enable) else $error("debug open while protected");
endmodule // sys_ctrl_chk

bind system_reset_power_control sys_ctrl_chk u_sys_ctrl_chk (.clock, .rst_n, .reset_pin_n, .watchdog_reset,
    .brownout_detector_low, .brownout_detector_reset, .osc_running, .flash_init_done, .supply_present, .rtc_alarm,
    .chip_reset_n, .flash_init_start, .fetch_addr, .vector_map_sram, .clk_sel, .cpu_clock_run, .regulator_on,
    .battery_ram_hold, .rtc_alarm_out, .brownout_irq, .power_down_wake, .protect);

// ---- sys_ctrl_pkg.sv ----
// shared constants and types of the system reset and power control block
package sys_ctrl_pkg;

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PROTECT = 8'h10;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CTL_PWRDN_BIT = 0;
    localparam int CTL_DEEP_BIT = 1;
    localparam int CTL_MAP_BIT = 2;
    localparam int CTL_CLKSEL_LSB = 4;
    localparam int CTL_ALARM_EN_BIT = 8;
    localparam logic [1:0] CLK_SEL_IRC = 2'h0;
    localparam logic MAP_BOOT_ROM = 1'b0;
    localparam logic ALARM_EN_RESET = 1'b1;
    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0000;

    // ----------------------------------------
    // status, cause and wake enable fields
    // ----------------------------------------
    localparam int ST_BOD1_BIT = 0;
    localparam int ST_BOD2_BIT = 1;
    localparam int ST_SUPPLY_BIT = 2;
    localparam int ST_PROT_LSB = 4;
    localparam int CAUSE_W = 5;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_BOD = 3;
    localparam int CAUSE_DEEP = 4;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;
    localparam int WAKE_EN_W = 5;
    localparam int WAKE_EDGE_BIT = 4;
    localparam logic [WAKE_EN_W-1:0] WAKE_EN_RESET = 5'h00;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {PROT_NONE, PROT_ONE, PROT_TWO, PROT_THREE} prot_level_t;

    typedef enum logic [2:0] {S_HOLD, S_COUNT, S_FLASH, S_RUN, S_PWRDN, S_PD_WAKE, S_DEEP} sys_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic debug_enable;
        logic isp_enable;
        logic isp_full_set;
        logic isp_sector0_lock;
        logic isp_mass_erase_only;
        logic isp_entry_pin_enable;
        logic iap_enable;
    } protect_t;

endpackage

// ---- sys_partner.sv ----
// far side model: oscillator start-up and flash initialisation
`timescale 1ns/1ns
module sys_partner
    import sys_ctrl_pkg::*;
#(
    parameter int OSC_DELAY = 5,
    parameter int FLASH_DELAY = 3
) (
    input wire logic clock,
    input wire logic regulator_on,
    input wire logic flash_init_start,
    input wire logic slow,
    input wire logic [31:0] pattern,
    output logic osc_running,
    output logic flash_init_done,
    output logic [31:0] protect_word
);
    // ------------------------------
    // model
    // ------------------------------
    int osc_cnt = 0;
    int fl_cnt = 0;
    // oscillator dies with the regulator and needs time to restart
    always_ff @(posedge clock) begin
        osc_cnt <= !regulator_on ? 0 : (osc_cnt < OSC_DELAY ? osc_cnt + 1 : osc_cnt);
        fl_cnt <= flash_init_start ? fl_cnt + 1 : 0;
    end
    assign osc_running = (osc_cnt >= OSC_DELAY);
    // slow mode stretches the flash wait fourfold
    assign flash_init_done = flash_init_start && (fl_cnt >= (slow ? 4 * FLASH_DELAY : FLASH_DELAY));
    // word valid only with done; otherwise the inverse, never a stale copy
    assign protect_word = flash_init_done ? pattern : ~pattern;
endmodule // sys_partner

// ---- system_reset_power_control.sv ----
// reset sequencing, brownout response, deep power-down and access protection
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module system_reset_power_control
    import sys_ctrl_pkg::*;
#(
    parameter int EDGE_IRQS = 46,
    parameter int LEVEL_IRQS = 4,
    parameter int WAKE_COUNT = 256,
    parameter logic [31:0] PATTERN_ONE = 32'h1111_1111,
    parameter logic [31:0] PATTERN_TWO = 32'h2222_2222,
    parameter logic [31:0] PATTERN_THREE = 32'h3333_3333
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic brownout_detector_low,
    input wire logic brownout_detector_reset,
    input wire logic supply_present,
    input wire logic osc_running,
    input wire logic flash_init_done,
    input wire logic [31:0] protect_word,
    input wire logic isp_entry_pin,
    input wire logic rtc_alarm,
    input wire logic [EDGE_IRQS-1:0] edge_irq,
    input wire logic [LEVEL_IRQS-1:0] level_irq,
    input wire bus_req_t bus,
    output logic [31:0] rdata,
    output logic chip_reset_n,
    output logic flash_init_start,
    output logic [31:0] fetch_addr,
    output logic vector_map_sram,
    output logic [1:0] clk_sel,
    output logic cpu_clock_run,
    output logic regulator_on,
    output logic battery_ram_hold,
    output logic rtc_alarm_out,
    output logic brownout_irq,
    output logic power_down_wake,
    output protect_t protect
);

    // wake wait counts 0 to WAKE_COUNT-1, WAKE_COUNT edges in all
    localparam int CNT_W = $clog2(WAKE_COUNT + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WAKE_COUNT - 1);

    // ----------------------------------------
    // state record
    // ----------------------------------------
    typedef struct packed {
        // sequencer
        sys_state_t st;
        logic [CNT_W-1:0] cnt;
        // software settings
        logic pwrdn_req;
        logic map_sram;
        logic [1:0] clk_sel;
        logic alarm_en;
        logic [WAKE_EN_W-1:0] wake_en;
        // sticky causes
        logic [CAUSE_W-1:0] cause;
        prot_level_t prot;
        logic isp_strap;
        // detector copies
        logic bod_low;
        logic bod_rst;
        logic supply_lost;
        // strobes and read data
        logic wake_pulse;
        logic [EDGE_IRQS-1:0] edge_prev;
        logic [31:0] rdata;
    } state_t;

    // current record and its next value
    state_t s;
    state_t next_s;
    // two-flop chain for the external reset pin
    logic pin_meta_n;
    logic pin_sync_n;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // flash pattern to protection level; any other word leaves access open
    // patterns are parameters so a product can pick its own
    function automatic prot_level_t decode_level(input logic [31:0] word);
        prot_level_t lvl;
        lvl = PROT_NONE;
        if (word == PATTERN_ONE) begin
            lvl = PROT_ONE;
        end else if (word == PATTERN_TWO) begin
            lvl = PROT_TWO;
        end else if (word == PATTERN_THREE) begin
            lvl = PROT_THREE;
        end
        return lvl;
    endfunction

    // access rights granted at each level
    // application programming is never gated, only debug and isp
    function automatic protect_t grant(input prot_level_t lvl, input logic strap);
        protect_t p;
        p.debug_enable = (lvl == PROT_NONE);
        p.isp_enable = (lvl != PROT_THREE);
        p.isp_full_set = (lvl == PROT_NONE);
        p.isp_sector0_lock = (lvl == PROT_ONE);
        p.isp_mass_erase_only = (lvl == PROT_TWO);
        p.isp_entry_pin_enable = strap && (lvl != PROT_THREE);
        p.iap_enable = 1'b1;
        return p;
    endfunction

    // control, wake and protection fields as seen after any reset
    function automatic state_t clear_soft(input state_t cur);
        state_t t;
        t = cur;
        // causes and detector copies survive so software sees why
        t.cnt = '0;
        t.pwrdn_req = 1'b0;
        t.map_sram = MAP_BOOT_ROM;
        t.clk_sel = CLK_SEL_IRC;
        t.alarm_en = ALARM_EN_RESET;
        t.wake_en = WAKE_EN_RESET;
        t.prot = PROT_NONE;
        t.isp_strap = 1'b0;
        t.wake_pulse = 1'b0;
        return t;
    endfunction

    // ----------------------------------------
    // reset pin synchroniser
    // ----------------------------------------
    // the pin is unrelated to clock; its release must not reach the sequencer raw
    // pin drops both flops at once; release walks through two edges
    always_ff @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            pin_meta_n <= 1'b0;
            pin_sync_n <= 1'b0;
        end else begin
            pin_meta_n <= 1'b1;
            pin_sync_n <= pin_meta_n;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic reset_src;
        logic [CAUSE_W-1:0] cause_set;
        logic [CAUSE_W-1:0] cause_clr;
        logic wake_any;
        // defaults: hold state, strobes low, read data idle
        next_s = s;
        cause_set = '0;
        cause_clr = '0;
        reset_src = 1'b0;
        wake_any = 1'b0;
        next_s.wake_pulse = 1'b0;
        next_s.rdata = '0;
        next_s.edge_prev = edge_irq;
        next_s.bod_low = brownout_detector_low;
        next_s.bod_rst = brownout_detector_reset;
        // bod reset stays a source for as long as the detector holds it
        reset_src = !pin_sync_n || watchdog_reset || brownout_detector_reset;
        // enabled level inputs, or any rising edge when edge wake is on
        wake_any = |(level_irq & s.wake_en[LEVEL_IRQS-1:0]);
        wake_any = wake_any || (s.wake_en[WAKE_EDGE_BIT] && |(edge_irq & ~s.edge_prev));

        // software writes, only while the processor runs
        // writes in any other state are dropped without notice
        if (s.st == S_RUN && bus.wr) begin
            if (bus.addr == OFF_CONTROL) begin
                next_s.pwrdn_req = bus.wdata[CTL_PWRDN_BIT];
                next_s.map_sram = bus.wdata[CTL_MAP_BIT];
                next_s.clk_sel = bus.wdata[CTL_CLKSEL_LSB +: 2];
                next_s.alarm_en = bus.wdata[CTL_ALARM_EN_BIT];
                // deep power-down wins when both mode bits are set
                if (bus.wdata[CTL_DEEP_BIT]) begin
                    next_s.st = S_DEEP;
                end else if (bus.wdata[CTL_PWRDN_BIT]) begin
                    next_s.st = S_PWRDN;
                end
            end else if (bus.addr == OFF_CAUSE) begin
                cause_clr = bus.wdata[CAUSE_W-1:0];
            end else if (bus.addr == OFF_WAKE_EN) begin
                next_s.wake_en = bus.wdata[WAKE_EN_W-1:0];
            end
        end

        // read data stands in the cycle after the strobe only
        // unmapped addresses read as zero
        if (bus.rd) begin
            if (bus.addr == OFF_CONTROL) begin
                next_s.rdata[CTL_PWRDN_BIT] = s.pwrdn_req;
                next_s.rdata[CTL_MAP_BIT] = s.map_sram;
                next_s.rdata[CTL_CLKSEL_LSB +: 2] = s.clk_sel;
                next_s.rdata[CTL_ALARM_EN_BIT] = s.alarm_en;
            end else if (bus.addr == OFF_STATUS) begin
                next_s.rdata[ST_BOD1_BIT] = s.bod_low;
                next_s.rdata[ST_BOD2_BIT] = s.bod_rst;
                next_s.rdata[ST_SUPPLY_BIT] = supply_present;
                next_s.rdata[ST_PROT_LSB +: 2] = s.prot;
            end else if (bus.addr == OFF_CAUSE) begin
                next_s.rdata[CAUSE_W-1:0] = s.cause;
            end else if (bus.addr == OFF_WAKE_EN) begin
                next_s.rdata[WAKE_EN_W-1:0] = s.wake_en;
            end else if (bus.addr == OFF_PROTECT) begin
                next_s.rdata[1:0] = s.prot;
            end
        end

        // sequencer
        case (s.st)
            S_DEEP: begin
                // logic supply is off: watchdog and brownout are dead here
                if (!supply_present) begin
                    next_s.supply_lost = 1'b1;
                end
                // returning supply is a cold start, ahead of alarm and pin
                if (s.supply_lost && supply_present) begin
                    next_s = clear_soft(next_s);
                    next_s.supply_lost = 1'b0;
                    next_s.st = S_HOLD;
                    cause_set[CAUSE_POR] = 1'b1;
                end else if (supply_present && (!pin_sync_n || rtc_alarm)) begin
                    next_s = clear_soft(next_s);
                    next_s.st = S_HOLD;
                    cause_set[CAUSE_DEEP] = 1'b1;
                    cause_set[CAUSE_PIN] = !pin_sync_n;
                end
            end
            default: begin
                // reset sources outrank every sequencer step
                if (reset_src) begin
                    next_s = clear_soft(next_s);
                    next_s.st = S_HOLD;
                    cause_set[CAUSE_PIN] = !pin_sync_n;
                    cause_set[CAUSE_WDT] = watchdog_reset;
                    cause_set[CAUSE_BOD] = brownout_detector_reset;
                end else begin
                    case (s.st)
                        S_HOLD: begin
                            // pin already released here, oscillator still to come
                            if (osc_running) begin
                                next_s.cnt = '0;
                                next_s.st = S_COUNT;
                            end
                        end
                        S_COUNT: begin
                            // oscillator loss restarts the wait
                            if (!osc_running) begin
                                next_s.st = S_HOLD;
                            end else if (s.cnt == CNT_LAST) begin
                                next_s.st = S_FLASH;
                            end else begin
                                next_s.cnt = s.cnt + 1'b1;
                            end
                        end
                        S_FLASH: begin
                            if (flash_init_done) begin
                                // taken once per start
                                next_s.prot = decode_level(protect_word);
                                next_s.isp_strap = isp_entry_pin;
                                next_s.st = S_RUN;
                            end
                        end
                        S_PWRDN: begin
                            // resets still act here
                            if (wake_any) begin
                                next_s.wake_pulse = 1'b1;
                                next_s.cnt = '0;
                                next_s.st = S_PD_WAKE;
                            end
                        end
                        S_PD_WAKE: begin
                            // clocks restart through the same fixed wait as a reset
                            if (s.cnt == CNT_LAST) begin
                                next_s.pwrdn_req = 1'b0;
                                next_s.st = S_RUN;
                            end else begin
                                next_s.cnt = s.cnt + 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase

        // a cause that arrives with its clear is kept
        // so a clear can never hide a fresh reset
        next_s.cause = (s.cause & ~cause_clr) | cause_set;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // power-on clears everything but alarm enable, which starts on; causes start with the power-on bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s.st <= S_HOLD;
            s.cnt <= '0;
            s.pwrdn_req <= 1'b0;
            s.map_sram <= MAP_BOOT_ROM;
            s.clk_sel <= CLK_SEL_IRC;
            s.alarm_en <= ALARM_EN_RESET;
            s.wake_en <= WAKE_EN_RESET;
            s.cause <= CAUSE_RESET;
            s.prot <= PROT_NONE;
            s.isp_strap <= 1'b0;
            s.bod_low <= 1'b0;
            s.bod_rst <= 1'b0;
            s.supply_lost <= 1'b0;
            s.wake_pulse <= 1'b0;
            s.edge_prev <= '0;
            s.rdata <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // the reset is a decode of the state flop, so it cannot glitch on inputs
    assign chip_reset_n = (s.st == S_RUN) || (s.st == S_PWRDN) || (s.st == S_PD_WAKE);
    // flash initialises for as long as the sequencer waits on it
    assign flash_init_start = (s.st == S_FLASH);
    // vectors at address 0 come from the boot block until remapped
    assign fetch_addr = RESET_VECTOR_ADDR;
    assign vector_map_sram = s.map_sram;
    assign clk_sel = s.clk_sel;
    // cpu clock stops in power-down and through its wake wait
    assign cpu_clock_run = (s.st == S_RUN);
    // only deep power-down switches the logic regulator off
    assign regulator_on = (s.st != S_DEEP);
    // backup RAM is fenced off whenever the main logic may be unpowered
    assign battery_ram_hold = (s.st == S_DEEP) || !supply_present;
    // alarm enable is lost with the logic supply, so it resets to on
    assign rtc_alarm_out = rtc_alarm && (s.alarm_en || s.st == S_DEEP);
    // raw level; masking is left to vectored_irq_ctrl
    assign brownout_irq = s.bod_low;
    // one-cycle strobe to the interrupt side on leaving power-down
    assign power_down_wake = s.wake_pulse;
    // rights follow the registered level, so they never change mid-run
    assign protect = grant(s.prot, s.isp_strap);
    assign rdata = s.rdata;

endmodule // system_reset_power_control

// ---- tb_system_reset_power_control.sv ----
// self-checking bench for the reset and power control block
`timescale 1ns/1ns
module tb_system_reset_power_control;
    import sys_ctrl_pkg::*;
    // ------------------------------
    // signals and instances
    // ------------------------------
    localparam logic [31:0] P1 = 32'h1111_1111;
    localparam logic [31:0] P2 = 32'h2222_2222;
    localparam logic [31:0] P3 = 32'h3333_3333;
    logic clock, rst_n, reset_pin_n, watchdog_reset, brownout_detector_low, brownout_detector_reset;
    logic supply_present, osc_running, flash_init_done, isp_entry_pin, rtc_alarm, slow;
    logic chip_reset_n, flash_init_start, vector_map_sram, cpu_clock_run, regulator_on, battery_ram_hold;
    logic rtc_alarm_out, brownout_irq, power_down_wake;
    logic [31:0] protect_word, pattern, rdata, fetch_addr;
    logic [45:0] edge_irq;
    logic [3:0] level_irq;
    logic [1:0] clk_sel;
    bus_req_t bus;
    protect_t protect;
    int num_errors = 0;
    int check_count = 0;
    system_reset_power_control #(.WAKE_COUNT(4), .PATTERN_ONE(P1), .PATTERN_TWO(P2), .PATTERN_THREE(P3))
        u_system_reset_power_control (.clock, .rst_n, .reset_pin_n, .watchdog_reset, .brownout_detector_low,
        .brownout_detector_reset, .supply_present, .osc_running, .flash_init_done, .protect_word, .isp_entry_pin,
        .rtc_alarm, .edge_irq, .level_irq, .bus, .rdata, .chip_reset_n, .flash_init_start, .fetch_addr,
        .vector_map_sram, .clk_sel, .cpu_clock_run, .regulator_on, .battery_ram_hold, .rtc_alarm_out,
        .brownout_irq, .power_down_wake, .protect);
    sys_partner u_sys_partner (.clock, .regulator_on, .flash_init_start, .slow, .pattern, .osc_running,
        .flash_init_done, .protect_word);
    // free-running system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // bus cycles: one strobe cycle, read data looked at in the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        chk(rdata, e);
    endtask
    // bounded wait for the end of the start-up sequence
    task automatic wait_run();
        int i;
        i = 0;
        while (chip_reset_n !== 1'b1 && i < 200) begin
            @(posedge clock);
            i++;
        end
        #1;
        chk(chip_reset_n, 1'b1);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog reset wipes map and clock choice; writes in reset are dropped
    task automatic t_wdt();
        wr(OFF_CONTROL, 32'h124);
        chk(vector_map_sram, 1'b1);
        rd(OFF_CONTROL, 32'h124);
        rd(8'h40, 32'h0);
        @(posedge clock);
        watchdog_reset <= 1'b1;
        step(1);
        watchdog_reset <= 1'b0;
        chk(chip_reset_n, 1'b0);
        wr(OFF_CONTROL, 32'h4);
        wait_run();
        chk(clk_sel, CLK_SEL_IRC);
        rd(OFF_CONTROL, 32'h100);
        rd(OFF_CAUSE, 32'h05);
    endtask
    // both brownout stages
    task automatic t_bod();
        brownout_detector_low <= 1'b1;
        step(2);
        chk(brownout_irq, 1'b1);
        rd(OFF_STATUS, 32'h5);
        brownout_detector_low <= 1'b0;
        brownout_detector_reset <= 1'b1;
        step(20);
        chk(chip_reset_n, 1'b0);
        rd(OFF_STATUS, 32'h6);
        brownout_detector_reset <= 1'b0;
        wait_run();
        rd(OFF_CAUSE, 32'h0D);
    endtask
    // every protection level via pin resets; level two with slow flash
    task automatic t_prot();
        logic [31:0] pats [4];
        int lv;
        pats = '{P1, P2, P3, 32'h0};
        for (int k = 0; k < 4; k++) begin
            pattern <= pats[k];
            slow <= (k == 1);
            reset_pin_n <= 1'b0;
            step(3);
            chk(chip_reset_n, 1'b0);
            reset_pin_n <= 1'b1;
            wait_run();
            lv = (k + 1) % 4;
            chk(protect, {lv == 0, lv != 3, lv == 0, lv == 1, lv == 2, lv != 3, 1'b1});
            rd(OFF_PROTECT, lv);
        end
    endtask
    // power-down, woken by a level input and then an edge input
    task automatic t_pd();
        for (int k = 0; k < 2; k++) begin
            wr(OFF_WAKE_EN, k ? 32'h10 : 32'h01);
            wr(OFF_CONTROL, 32'h101);
            level_irq[3] <= 1'b1;
            step(3);
            chk({cpu_clock_run, power_down_wake}, 2'b00);
            if (k) edge_irq[45] <= 1'b1; else level_irq[0] <= 1'b1;
            step(1);
            chk(power_down_wake, 1'b1);
            level_irq <= '0;
            edge_irq <= '0;
            step(8);
            chk(cpu_clock_run, 1'b1);
        end
        rd(OFF_CONTROL, 32'h100);
    endtask
    // deep power-down: alarm wake, then supply loss and return
    task automatic t_deep();
        wr(OFF_CONTROL, 32'h2);
        chk({regulator_on, battery_ram_hold}, 2'b01);
        watchdog_reset <= 1'b1;
        step(1);
        watchdog_reset <= 1'b0;
        rtc_alarm <= 1'b1;
        #1;
        chk({regulator_on, rtc_alarm_out}, 2'b01);
        wait_run();
        rtc_alarm <= 1'b0;
        rd(OFF_CAUSE, 32'h1F);
        wr(OFF_CAUSE, 32'h1F);
        wr(OFF_CONTROL, 32'h2);
        supply_present <= 1'b0;
        step(5);
        chk({regulator_on, battery_ram_hold}, 2'b01);
        supply_present <= 1'b1;
        wait_run();
        rd(OFF_CAUSE, 32'h01);
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        reset_pin_n = 1'b1;
        watchdog_reset = 1'b0;
        brownout_detector_low = 1'b0;
        brownout_detector_reset = 1'b0;
        supply_present = 1'b1;
        isp_entry_pin = 1'b1;
        rtc_alarm = 1'b0;
        slow = 1'b0;
        edge_irq = '0;
        level_irq = '0;
        bus = '0;
        pattern = '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        wait_run();
        chk(fetch_addr, RESET_VECTOR_ADDR);
        rd(OFF_CAUSE, 32'h01);
        t_wdt();
        t_bod();
        t_prot();
        t_pd();
        t_deep();
        end_sim();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #80000;
        num_errors++;
        $display("Error at %0t: run timed out", $time);
        end_sim();
    end
endmodule // tb_system_reset_power_control
